// File: verification/fm_reset_pulse_and_phase_counter_tb.sv
// Self-checking bench for the FM reset pulse and phase counter
`timescale 1ns/1ps
module fm_reset_pulse_and_phase_counter_tb;
  localparam int PW = fmrpc_pkg::PULSE_TICKS * fmrpc_pkg::REF_DIV;
  localparam logic [31:0] BAD = 32'h0000_0010;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, pos_en, neg_en, cclk, count_up;
  logic rem_pin, add_pin, gate_pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] dac;
  int n_fail = 0;
  int num_checks = 0;

  always #5 aclk = ~aclk;

  fmrpc_far_model far (.aclk(aclk), .remove_cycle_latch(rem_pin), .add_cycle_latch(add_pin),
    .loop_cycle_gate(gate_pin));
  fmrpc_core dut (.aclk(aclk), .aresetn(aresetn), .remove_cycle_latch(rem_pin), .add_cycle_latch(add_pin),
    .loop_cycle_gate(gate_pin), .positive_reset_current_en(pos_en), .negative_reset_current_en(neg_en),
    .counter_clock(cclk), .count_up(count_up), .phase_dac_code(dac), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (awready === 1'h1 && awvalid) awvalid <= 1'h0;
      if (wready === 1'h1 && wvalid) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        chk(32'(bresp), 32'(er), "write response");
        bready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (arready === 1'h1 && arvalid) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        chk(rdata, ed, "read data");
        chk(32'(rresp), 32'(er), "read response");
        rready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask

  // Waits for one pulse, measures it and the counter step that follows
  task automatic meas(input logic is_add, input logic [9:0] exp_dac);
    int n;
    n = 0;
    while ((is_add ? neg_en : pos_en) !== 1'h1 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(count_up), 32'(!is_add), "direction at pulse");
    n = 0;
    while ((is_add ? neg_en : pos_en) === 1'h1 && n < 100) begin
      chk({30'h0, cclk, is_add ? pos_en : neg_en}, {30'h0, n == 0, 1'h0}, "clock or other switch in pulse");
      @(posedge aclk);
      n++;
    end
    chk(32'(n), 32'(PW), "pulse width");
    repeat (4) @(posedge aclk);
    chk(32'(cclk), 32'h1, "counter clock idle");
    chk(32'(dac), 32'(exp_dac), "phase code after pulse");
    repeat (60) @(posedge aclk);
    chk(32'({pos_en, neg_en}), 32'h0, "single pulse");
  endtask

  task automatic t_reset();
    chk({26'h0, pos_en, neg_en, count_up, cclk, 2'h0}, 32'h4, "outputs after reset");
    chk(32'(dac), 32'h200, "code after reset");
    axi_rd(fmrpc_pkg::CTRL_ADDR, 32'h1, fmrpc_pkg::RESP_OKAY);
    axi_rd(fmrpc_pkg::STAT_ADDR, 32'h200, fmrpc_pkg::RESP_OKAY);
  endtask

  task automatic t_events();
    axi_wr(fmrpc_pkg::CTRL_ADDR, 32'h0, fmrpc_pkg::RESP_OKAY);
    far.raise_request(1'h0);
    far.loop_gate();
    meas(1'h0, 10'h201);
    far.raise_request(1'h1);
    far.loop_gate();
    meas(1'h1, 10'h200);
  endtask

  task automatic t_dc_freeze();
    axi_wr(fmrpc_pkg::CTRL_ADDR, 32'h2, fmrpc_pkg::RESP_OKAY);
    far.raise_request(1'h0);
    far.loop_gate();
    meas(1'h0, 10'h200);
    axi_wr(fmrpc_pkg::CTRL_ADDR, 32'h0, fmrpc_pkg::RESP_OKAY);
  endtask

  task automatic t_gate_held();
    far.raise_request(1'h0);
    repeat (100) @(posedge aclk);
    chk(32'(pos_en), 32'h0, "no pulse before gate");
    far.loop_gate();
    meas(1'h0, 10'h201);
  endtask

  task automatic t_modulation_off_control();
    int i;
    axi_wr(fmrpc_pkg::CTRL_ADDR, 32'h1, fmrpc_pkg::RESP_OKAY);
    far.raise_request(1'h1);
    far.loop_gate();
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      chk(32'(neg_en), 32'h0, "no pulse with Modulation_off_control");
    end
    axi_wr(fmrpc_pkg::CTRL_ADDR, 32'h0, fmrpc_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(dac), 32'h200, "preset on FM select");
    meas(1'h1, 10'h1FF);
  endtask

  task automatic t_regs();
    axi_wr(fmrpc_pkg::CTRL_ADDR, 32'h0, fmrpc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(dac), 32'h1FF, "no reload while FM on");
    axi_wr(fmrpc_pkg::STAT_ADDR, 32'h0, fmrpc_pkg::RESP_OKAY);
    axi_rd(fmrpc_pkg::STAT_ADDR, 32'h0008_01FF, fmrpc_pkg::RESP_OKAY);
    wstrb <= 4'h0;
    axi_wr(fmrpc_pkg::CTRL_ADDR, 32'h1, fmrpc_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axi_wr(BAD, 32'h3, fmrpc_pkg::RESP_SLVERR);
    axi_rd(BAD, 32'h0, fmrpc_pkg::RESP_SLVERR);
    axi_rd(fmrpc_pkg::CTRL_ADDR, 32'h0, fmrpc_pkg::RESP_OKAY);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    t_reset();
    t_events();
    t_dc_freeze();
    t_gate_held();
    t_modulation_off_control();
    t_regs();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end
endmodule // fm_reset_pulse_and_phase_counter_tb

// File: verification/fmrpc_far_model.sv
// Threshold latch and loop gate model driving the request pins
`timescale 1ns/1ps
module fmrpc_far_model (
  input wire logic aclk,
  output logic remove_cycle_latch,
  output logic add_cycle_latch,
  output logic loop_cycle_gate
);
  initial begin
    remove_cycle_latch = 1'h0;
    add_cycle_latch = 1'h0;
    loop_cycle_gate = 1'h0;
  end
  // Latch output rises and is held long enough to be seen, then falls back to idle
  task automatic raise_request(input logic is_add);
    @(posedge aclk);
    if (is_add) add_cycle_latch <= 1'h1;
    else remove_cycle_latch <= 1'h1;
    repeat (6) @(posedge aclk);
    remove_cycle_latch <= 1'h0;
    add_cycle_latch <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask
  // Fixed release point of one loop cycle
  task automatic loop_gate();
    @(posedge aclk);
    loop_cycle_gate <= 1'h1;
    repeat (6) @(posedge aclk);
    loop_cycle_gate <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask
endmodule // fmrpc_far_model

// File: verilog/fmrpc_core.sv
// FM reset pulse timing, count direction and phase counter with AXI4-Lite control
// Overview of operation
// - Pulse timing runs on a 5 MHz reference divided from the master clock.
// - The reference ticks only while FM is selected.
// - A remove-cycle rising edge sets the remove request flop.
// - Request feeds a two-stage chain; second stage high clears the request.
// - Second stage high forms a pulse of exactly two reference periods.
// - One pulse per remove request; it enables the positive reset current.
// - Pulses combine in a NOR counter clock; remove pulse end counts up.
// - Add path is identical; its pulse enables the negative reset current.
// - End of add pulse decrements the phase counter by one.
// - Remove request sets direction up, add request sets it down.
// - Counter steps once up per remove, once down per add event.
// - Counter counts only while dc_modulation_select select is low; high freezes it.
// - Counter loads its preset each time FM becomes selected.
// - Preset is the midscale code 512 of a 1024 full scale.
// - Ten counter bits drive the phase deviation converter code.
// - No reload of the preset while FM stays on.
// - Requests are latched, then released at a fixed loop-cycle gate point.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fmrpc_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic remove_cycle_latch,
  input wire logic add_cycle_latch,
  input wire logic loop_cycle_gate,
  output logic positive_reset_current_en,
  output logic negative_reset_current_en,
  output logic counter_clock,
  output logic count_up,
  output logic [fmrpc_pkg::CNT_W-1:0] phase_dac_code,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  fmrpc_pkg::fmrpc_core_s st_r;
  fmrpc_pkg::fmrpc_core_s st_nxt;
  logic rem_req;
  logic add_req;
  logic rem_pulse;
  logic add_pulse;
  logic rem_idle;
  logic add_idle;
  logic rem_rel;
  logic add_rel;
  logic gate_rise;
  logic fm_on;
  logic fm_rise;
  logic cclk_rise;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [1:0] rd_hit;
  logic [1:0] wr_hit;
  logic [fmrpc_pkg::DIV_W-1:0] gap_r;
  logic seen_r;
  // Latest rise of a pulse after its release: two reference periods plus the chain stages
  localparam int FIRE_MAX = fmrpc_pkg::PULSE_TICKS * fmrpc_pkg::REF_DIV + fmrpc_pkg::PULSE_TICKS;

  // Three-stage pin synchroniser; level moves once stages two and three agree
  function automatic fmrpc_pkg::fmrpc_sync_s sync_step(
    input fmrpc_pkg::fmrpc_sync_s s,
    input logic pin
  );
    fmrpc_pkg::fmrpc_sync_s n;
    n = s;
    n.s1 = pin;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) begin
      n.lv = s.s3;
    end
    return n;
  endfunction

  function automatic logic sync_rise(input fmrpc_pkg::fmrpc_sync_s s);
    return s.s2 & s.s3 & ~s.lv;
  endfunction

  // One-hot register hit: bit 0 control, bit 1 status
  function automatic logic [1:0] reg_hit(input logic [31:0] a);
    logic [1:0] h;
    h[0] = a[31:2] == fmrpc_pkg::CTRL_ADDR[31:2];
    h[1] = a[31:2] == fmrpc_pkg::STAT_ADDR[31:2];
    return h;
  endfunction

  fmrpc_pulse_gen u_remove_pulse_shift_chain (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_tick(st_r.ref_tick),
    .req_set(rem_rel),
    .req_q(rem_req),
    .pulse(rem_pulse),
    .idle(rem_idle)
  );

  fmrpc_pulse_gen u_add_pulse_shift_chain (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_tick(st_r.ref_tick),
    .req_set(add_rel),
    .req_q(add_req),
    .pulse(add_pulse),
    .idle(add_idle)
  );

  // Release only when both generators are idle so pulses never overlap
  assign gate_rise = sync_rise(st_r.gate_sy);
  assign rem_rel = st_r.rem_pend & gate_rise & rem_idle & add_idle;
  assign add_rel = st_r.add_pend & gate_rise & rem_idle & add_idle & ~st_r.rem_pend;
  assign fm_on = ~st_r.modulation_off_control;
  assign fm_rise = fm_on & ~st_r.fm_on_q;
  assign cclk_rise = ~(rem_pulse | add_pulse) & ~st_r.cclk;
  assign aw_take = awvalid & st_r.awready;
  assign w_take = wvalid & st_r.wready;
  assign ar_take = arvalid & st_r.arready;
  assign rd_hit = reg_hit(araddr);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rem_sy = sync_step(st_r.rem_sy, remove_cycle_latch);
    st_nxt.add_sy = sync_step(st_r.add_sy, add_cycle_latch);
    st_nxt.gate_sy = sync_step(st_r.gate_sy, loop_cycle_gate);
    // A new edge in the release cycle keeps the request pending
    st_nxt.rem_pend = sync_rise(st_r.rem_sy) | (st_r.rem_pend & ~rem_rel);
    st_nxt.add_pend = sync_rise(st_r.add_sy) | (st_r.add_pend & ~add_rel);

    // Reference divider, cleared and kept at zero while FM is off
    if (!fm_on || st_r.div == fmrpc_pkg::DIV_LAST) begin
      st_nxt.div = '0;
    end else begin
      st_nxt.div = st_r.div + fmrpc_pkg::DIV_ONE;
    end
    st_nxt.ref_tick = fm_on && st_r.div == fmrpc_pkg::DIV_LAST;

    if (rem_req) begin
      st_nxt.dir_up = 1'b1;
    end else if (add_req) begin
      st_nxt.dir_up = 1'b0;
    end

    st_nxt.cclk = ~(rem_pulse | add_pulse);
    st_nxt.fm_on_q = fm_on;
    if (fm_rise) begin
      st_nxt.cnt = fmrpc_pkg::CNT_PRESET;
    end else if (cclk_rise && fm_on && !st_r.dc_sel) begin
      if (st_r.dir_up) begin
        st_nxt.cnt = st_r.cnt + fmrpc_pkg::CNT_STEP;
      end else begin
        st_nxt.cnt = st_r.cnt - fmrpc_pkg::CNT_STEP;
      end
    end

    // AXI4-Lite write: address and data taken in either order
    if (aw_take) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (w_take) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    wr_hit = reg_hit(st_nxt.aw_addr);
    if (st_nxt.aw_got && st_nxt.w_got && !st_nxt.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = fmrpc_pkg::RESP_SLVERR;
      if (wr_hit[0]) begin
        st_nxt.bresp = fmrpc_pkg::RESP_OKAY;
        if (st_nxt.w_strb[0]) begin
          st_nxt.modulation_off_control = st_nxt.w_data[fmrpc_pkg::CTRL_MODULATION_OFF_CONTROL_BIT];
          st_nxt.dc_sel = st_nxt.w_data[fmrpc_pkg::CTRL_DC_SEL_BIT];
        end
      end else if (wr_hit[1]) begin
        st_nxt.bresp = fmrpc_pkg::RESP_OKAY;
      end
    end
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;

    // AXI4-Lite read
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = '0;
      st_nxt.rresp = fmrpc_pkg::RESP_OKAY;
      if (rd_hit[0]) begin
        st_nxt.rdata[fmrpc_pkg::CTRL_MODULATION_OFF_CONTROL_BIT] = st_r.modulation_off_control;
        st_nxt.rdata[fmrpc_pkg::CTRL_DC_SEL_BIT] = st_r.dc_sel;
      end else if (rd_hit[1]) begin
        st_nxt.rdata[fmrpc_pkg::CNT_W-1:0] = st_r.cnt;
        st_nxt.rdata[fmrpc_pkg::STAT_DIR_BIT] = st_r.dir_up;
        st_nxt.rdata[fmrpc_pkg::STAT_POS_BIT] = rem_pulse;
        st_nxt.rdata[fmrpc_pkg::STAT_NEG_BIT] = add_pulse;
        st_nxt.rdata[fmrpc_pkg::STAT_FM_ON_BIT] = fm_on;
      end else begin
        st_nxt.rresp = fmrpc_pkg::RESP_SLVERR;
      end
    end
    st_nxt.arready = ~st_nxt.rvalid;

    if (!aresetn) begin
      st_nxt = '0;
      st_nxt.modulation_off_control = 1'b1;
      st_nxt.cclk = 1'b1;
      st_nxt.cnt = fmrpc_pkg::CNT_PRESET;
    end
  end

  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end

  assign positive_reset_current_en = rem_pulse;
  assign negative_reset_current_en = add_pulse;
  assign counter_clock = st_r.cclk;
  assign count_up = st_r.dir_up;
  assign phase_dac_code = st_r.cnt;
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

  // Cycles since the previous reference tick, for the period check
  always_ff @(posedge aclk) begin
    if (!aresetn || !fm_on) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (st_r.ref_tick) begin
      gap_r <= '0;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + fmrpc_pkg::DIV_ONE;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rem_go;
    rem_rel && fm_on;
  endsequence

  sequence s_rem_pulse;
    ##[1:FIRE_MAX] $rose(positive_reset_current_en);
  endsequence

  sequence s_add_go;
    add_rel && fm_on;
  endsequence

  sequence s_add_pulse;
    ##[1:FIRE_MAX] $rose(negative_reset_current_en);
  endsequence

  property p_step(logic fall, logic other, logic [fmrpc_pkg::CNT_W-1:0] delta);
    fall && !other && fm_on && st_r.fm_on_q && !st_r.dc_sel
      |=> phase_dac_code == $past(phase_dac_code) + delta;
  endproperty

  a_ref_period: assert property (st_r.ref_tick && seen_r |-> gap_r == fmrpc_pkg::DIV_LAST)
    else $error("reference tick period wrong");
  a_ref_gated: assert property (st_r.modulation_off_control |=> !st_r.ref_tick)
    else $error("reference ticks while FM is off");
  a_rem_fire: assert property (s_rem_go |-> s_rem_pulse)
    else $error("remove release gave no reset pulse");
  a_add_fire: assert property (s_add_go |-> s_add_pulse)
    else $error("add release gave no reset pulse");
  a_count_up: assert property (p_step($fell(rem_pulse), add_pulse, fmrpc_pkg::CNT_STEP))
    else $error("counter did not step up after remove pulse");
  a_count_down: assert property (p_step($fell(add_pulse), rem_pulse, -fmrpc_pkg::CNT_STEP))
    else $error("counter did not step down after add pulse");
  a_dir_latch: assert property ($rose(rem_req) |=> count_up ##0 (count_up throughout !add_req [*1]))
    else $error("direction not set up by remove request");
  a_dc_freeze: assert property (st_r.dc_sel && st_r.fm_on_q && fm_on |=> $stable(phase_dac_code))
    else $error("counter moved in dc_modulation_select mode");
  a_preset_load: assert property (fm_rise |=> phase_dac_code == fmrpc_pkg::CNT_PRESET)
    else $error("preset not loaded on FM selection");
  a_no_reload: assert property (fm_on && st_r.fm_on_q && !cclk_rise |=> $stable(phase_dac_code))
    else $error("counter changed without a counter clock");
  a_gate_point: assert property ($rose(rem_req) || $rose(add_req) |-> $past(gate_rise))
    else $error("request released outside the gate point");
  a_reset_quiet: assert property ($rose(aresetn) |-> !positive_reset_current_en && !count_up)
    else $error("pulse or direction set after reset");

  // Pulse exclusivity and the registered counter clock
  a_pulse_excl: assert property (!(positive_reset_current_en && negative_reset_current_en))
    else $error("remove and add pulses overlap");
  a_cclk_nor: assert property (counter_clock == !($past(positive_reset_current_en) || $past(negative_reset_current_en)))
    else $error("counter clock is not the delayed NOR of the pulses");
  a_tick_single: assert property (st_r.ref_tick |=> !st_r.ref_tick)
    else $error("reference tick longer than one cycle");

  // Direction must be settled for the whole pulse that precedes the count
  a_dir_down: assert property ($rose(add_req) |=> !count_up)
    else $error("direction not set down by add request");
  a_pos_dir: assert property (positive_reset_current_en |-> count_up)
    else $error("direction not up during remove pulse");
  a_neg_dir: assert property (negative_reset_current_en |-> !count_up)
    else $error("direction not down during add pulse");
  a_modulation_off_control_freeze: assert property (st_r.modulation_off_control |=> $stable(phase_dac_code))
    else $error("counter moved while FM is off");

  // Pending requests wait for the gate and then reach the request flops
  a_rem_hold: assert property (st_r.rem_pend && !rem_rel |=> st_r.rem_pend)
    else $error("pending remove request lost before release");
  a_add_hold: assert property (st_r.add_pend && !add_rel |=> st_r.add_pend)
    else $error("pending add request lost before release");
  a_rem_rel_req: assert property (rem_rel |=> rem_req)
    else $error("released remove request did not set its flop");
  a_add_rel_req: assert property (add_rel |=> add_req)
    else $error("released add request did not set its flop");
endmodule // fmrpc_core

// File: verilog/fmrpc_pkg.sv
// Constants and state types of the FM reset pulse and phase counter
package fmrpc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int REF_HZ = 5_000_000;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;
  localparam int PULSE_NS = 400;
  localparam int REF_NS = 1_000_000_000 / REF_HZ;
  localparam int PULSE_TICKS = PULSE_NS / REF_NS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_PRESET = 10'h200;
  localparam logic [CNT_W-1:0] CNT_STEP = 10'h001;
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] STAT_ADDR = 32'h0000_0004;
  localparam int CTRL_MODULATION_OFF_CONTROL_BIT = 0;
  localparam int CTRL_DC_SEL_BIT = 1;
  localparam int STAT_DIR_BIT = 16;
  localparam int STAT_POS_BIT = 17;
  localparam int STAT_NEG_BIT = 18;
  localparam int STAT_FM_ON_BIT = 19;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lv;
  } fmrpc_sync_s;

  typedef struct packed {
    logic req;
    logic st1;
    logic st2;
  } fmrpc_pgen_s;

  typedef struct packed {
    fmrpc_sync_s rem_sy;
    fmrpc_sync_s add_sy;
    fmrpc_sync_s gate_sy;
    logic rem_pend;
    logic add_pend;
    logic [DIV_W-1:0] div;
    logic ref_tick;
    logic modulation_off_control;
    logic dc_sel;
    logic fm_on_q;
    logic dir_up;
    logic cclk;
    logic [CNT_W-1:0] cnt;
    logic aw_got;
    logic [31:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fmrpc_core_s;
endpackage

// File: verilog/fmrpc_pulse_gen.sv
// Request flop and two-stage reference-clocked chain forming one reset pulse
`timescale 1ns/1ps
module fmrpc_pulse_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_tick,
  input wire logic req_set,
  output logic req_q,
  output logic pulse,
  output logic idle
);
  fmrpc_pkg::fmrpc_pgen_s st_r;
  fmrpc_pkg::fmrpc_pgen_s st_nxt;
  logic [1:0] tk_r;

  always_comb begin
    st_nxt = st_r;
    if (st_r.st2) begin
      st_nxt.req = 1'b0;
    end
    if (req_set) begin
      st_nxt.req = 1'b1;
    end
    if (ref_tick) begin
      st_nxt.st1 = st_r.req;
      st_nxt.st2 = st_r.st1;
    end
    if (!aresetn) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end

  assign req_q = st_r.req;
  assign pulse = st_r.st2;
  assign idle = ~(st_r.req | st_r.st1 | st_r.st2);

  // Reference ticks seen while the pulse is high
  always_ff @(posedge aclk) begin
    if (!aresetn || !st_r.st2) begin
      tk_r <= 2'h0;
    end else if (ref_tick) begin
      tk_r <= tk_r + 2'h1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_req_set_edge: assert property (req_set |=> req_q)
    else $error("request flop not set by request edge");
  a_req_clear: assert property (pulse && !req_set |=> !req_q)
    else $error("request flop not cleared by second stage");
  a_chain_step: assert property (ref_tick |=> st_r.st1 == $past(req_q))
    else $error("first stage did not follow request flop");
  a_pulse_width: assert property ($fell(pulse) |-> tk_r == fmrpc_pkg::PULSE_TICKS)
    else $error("reset pulse not two reference periods");
endmodule // fmrpc_pulse_gen
